// [include/sop_logic_pkg.sv]
// Package: constants and types for the registered sum-of-products logic block
package sop_logic_pkg;

   // =========================================================
   // Array geometry
   localparam int unsigned NUM_DED_IN   = 8;   // Dedicated array inputs
   localparam int unsigned NUM_MACRO    = 8;   // Output macrocells
   localparam int unsigned NUM_ARRAY_IN = 16;  // Array input signals
   localparam int unsigned NUM_LIT      = 32;  // True and complement literals
   localparam int unsigned TERMS_PER_MC = 8;   // Product terms per macrocell
   localparam int unsigned NUM_TERMS    = NUM_MACRO * TERMS_PER_MC;
   localparam int unsigned FUSE_BITS    = NUM_TERMS * NUM_LIT;
   localparam int unsigned REG_TERMS    = 8;   // Terms summed by a registered cell
   localparam int unsigned COMB_TERMS   = 7;   // Terms summed by a combinational cell
   localparam int unsigned NUM_SHARED16 = 6;   // Combinational cells usable as inputs, all-comb mode

   // =========================================================
   // Output arrangements, one-hot
   typedef enum logic [3:0] {
      ARR_ALL_REG  = 4'h1,  // 8 registered
      ARR_ALL_COMB = 4'h2,  // 8 combinational
      ARR_R6_C2    = 4'h4,  // 6 registered, 2 combinational
      ARR_R4_C4    = 4'h8   // 4 registered, 4 combinational
   } arrange_e;

   localparam logic [7:0] REG_MASK_ALL  = 8'hFF;
   localparam logic [7:0] REG_MASK_NONE = 8'h00;
   localparam logic [7:0] REG_MASK_R6   = 8'h7E;
   localparam logic [7:0] REG_MASK_R4   = 8'h3C;
   localparam logic [7:0] SHARED_MASK16 = 8'h7E;
   localparam logic [7:0] REG_RESET     = 8'h00;  // Q low after reset

   // Fuse state: erased cell connects literal (value 0 = connected)
   localparam logic FUSE_ERASED = 1'b0;

endpackage : sop_logic_pkg

// [rtl/sop_logic_device.sv]
// Registered sum-of-products logic device: macrocells, feedback, preload and security
`timescale 1ns/10ps
module sop_logic_device
   import sop_logic_pkg::*;
// Operation
// [RULE1] Four output arrangements: 8 reg, 8 comb, 6 reg plus 2, 4 reg plus 4.
// [RULE2] Array takes up to sixteen inputs and drives up to eight outputs.
// [RULE3] Erased cells connect both literals; programming a cell drops that literal.
// [RULE4] Each output is an OR of selected product terms.
// [RULE5] Combinational outputs may serve as extra array inputs, six in all-comb mode.
// [RULE6] Each register feeds its inverted state back into the array.
// [RULE7] At power-up registers clear: Q low, inverted Q high.
// [RULE8] With security set, verify readback returns no array contents.
// [RULE9] Registers can be preloaded with a known state, bypassing the logic.
// [RULE10] Board logic should hold unused inputs low.
// [RULE11] Registered pins pass an inverting buffer, so cleared registers read high.
// [RULE12] Board must not clock until setup is met after power-up reset.
// [RULE13] Registers capture their sum on the rising edge of the clock.
(
   input  wire logic                                   sys_clk_i,       // System clock
   input  wire logic                                   rst_i,           // Async reset, high
   input  wire logic                                   dev_clk_i,       // Device clock pin
   input  wire logic [sop_logic_pkg::NUM_DED_IN-1:0]   ded_in_i,        // Dedicated inputs
   input  wire logic                                   reg_oe_n_i,      // Registered output enable, low
   input  wire logic [sop_logic_pkg::NUM_MACRO-1:0]    io_in_i,         // Output pins read back
   input  wire sop_logic_pkg::arrange_e                arrange_i,       // Output arrangement
   input  wire logic [sop_logic_pkg::FUSE_BITS-1:0]    fuse_i,          // AND array pattern
   input  wire logic [sop_logic_pkg::NUM_TERMS-1:0]    oe_term_sel_i,   // Term used as comb enable
   input  wire logic                                   secure_set_i,    // Pulse: set security
   input  wire logic                                   preload_i,       // Preload strobe
   input  wire logic [sop_logic_pkg::NUM_MACRO-1:0]    preload_data_i,  // Preload Q values
   input  wire logic                                   verify_i,        // Verify read request
   input  wire logic [5:0]                             verify_term_i,   // Term row to read
   output      logic [sop_logic_pkg::NUM_MACRO-1:0]    io_out_o,        // Output pin levels
   output      logic [sop_logic_pkg::NUM_MACRO-1:0]    io_oe_n_o,       // Output enable, low drives
   output      logic [sop_logic_pkg::NUM_LIT-1:0]      verify_data_o,   // Readback row
   output      logic                                   verify_valid_o,  // Readback strobe
   output      logic                                   secure_o         // Security state
);

   typedef struct packed {
      logic [2:0]           clk_sync;   // Pin clock synchroniser and edge history
      logic [NUM_DED_IN-1:0] ded_s1;
      logic [NUM_DED_IN-1:0] ded_s2;
      logic [NUM_MACRO-1:0]  io_s1;
      logic [NUM_MACRO-1:0]  io_s2;
      logic [1:0]            oe_sync;
      logic [NUM_MACRO-1:0]  q;          // Macrocell registers
      logic [NUM_MACRO-1:0]  pin;
      logic [NUM_MACRO-1:0]  pin_oe_n;
      logic [NUM_LIT-1:0]    vdata;
      logic                  vvalid;
      logic                  secure;
   } state_s;

   state_s st_reg;
   state_s st_next;

   logic [NUM_ARRAY_IN-1:0] array_in;
   logic [NUM_TERMS-1:0]    term;
   logic [NUM_MACRO-1:0]    reg_mask;
   logic [NUM_MACRO-1:0]    fb_mask;
   logic [NUM_MACRO-1:0]    sum;
   logic [NUM_MACRO-1:0]    comb_oe;

   // =========================================================
   // Arrangement decode, used for registers and for feedback choice
   function automatic logic [NUM_MACRO-1:0] reg_mask_of(input arrange_e a);
      case (a)
         ARR_ALL_REG:  reg_mask_of = REG_MASK_ALL;
         ARR_ALL_COMB: reg_mask_of = REG_MASK_NONE;
         ARR_R6_C2:    reg_mask_of = REG_MASK_R6;
         ARR_R4_C4:    reg_mask_of = REG_MASK_R4;
         default:      reg_mask_of = REG_MASK_ALL;
      endcase
   endfunction : reg_mask_of

   // Pins that may feed the array as inputs
   function automatic logic [NUM_MACRO-1:0] fb_pin_of(input arrange_e a);
      case (a)
         ARR_ALL_COMB: fb_pin_of = SHARED_MASK16;
         default:      fb_pin_of = ~reg_mask_of(a);
      endcase
   endfunction : fb_pin_of

   assign reg_mask = reg_mask_of(arrange_i);  // [RULE1]
   assign fb_mask  = fb_pin_of(arrange_i);

   // =========================================================
   // Array inputs: eight dedicated, then one per macrocell
   genvar gm;
   generate
      for (gm = 0; gm < NUM_MACRO; gm++) begin : g_fb
         assign array_in[gm] = st_reg.ded_s2[gm];  // [RULE2]
         assign array_in[NUM_DED_IN+gm] =
            reg_mask[gm] ? ~st_reg.q[gm] :                   // [RULE6]
            (fb_mask[gm] ? st_reg.io_s2[gm] : 1'b0);         // [RULE5]
      end
   endgenerate

   sop_term_array u_array (
      .array_in_i (array_in),
      .fuse_i     (fuse_i),
      .term_o     (term)
   );

   // =========================================================
   // OR sums: registered cells use 8 terms; combinational cells 7, first term is enable
   generate
      for (gm = 0; gm < NUM_MACRO; gm++) begin : g_sum
         logic [TERMS_PER_MC-1:0] t;
         assign t = term[gm*TERMS_PER_MC +: TERMS_PER_MC];
         assign sum[gm] = reg_mask[gm] ? (|t[REG_TERMS-1:0])                      // [RULE4]
                                       : (|t[TERMS_PER_MC-1:TERMS_PER_MC-COMB_TERMS]);
         assign comb_oe[gm] = oe_term_sel_i[gm*TERMS_PER_MC] ? t[0] : 1'b1;
      end
   endgenerate

   // =========================================================
   // Next state
   always_comb begin
      st_next          = st_reg;
      st_next.clk_sync = {st_reg.clk_sync[1:0], dev_clk_i};
      st_next.ded_s1   = ded_in_i;
      st_next.ded_s2   = st_reg.ded_s1;
      st_next.io_s1    = io_in_i;
      st_next.io_s2    = st_reg.io_s1;
      st_next.oe_sync  = {st_reg.oe_sync[0], reg_oe_n_i};
      // Preload wins over the clock so a tester gets a known state
      if (preload_i) begin
         st_next.q = preload_data_i & reg_mask;  // [RULE9]
      end else if (st_reg.clk_sync[1] && !st_reg.clk_sync[2]) begin
         st_next.q = sum & reg_mask;  // [RULE13]
      end
      // Registered pins inverted; combinational pins are active-low sums
      for (int i = 0; i < NUM_MACRO; i++) begin
         if (reg_mask[i]) begin
            st_next.pin[i]      = ~st_next.q[i];  // [RULE11]
            st_next.pin_oe_n[i] = st_reg.oe_sync[1];
         end else begin
            st_next.pin[i]      = ~sum[i];
            st_next.pin_oe_n[i] = ~comb_oe[i];
         end
      end
      // Security is sticky until reset (stands in for erasure)
      if (secure_set_i) begin
         st_next.secure = 1'b1;
      end
      st_next.vvalid = verify_i;
      if (verify_i) begin
         st_next.vdata = (st_reg.secure || secure_set_i) ? '0  // [RULE8]
                         : fuse_i[verify_term_i*NUM_LIT +: NUM_LIT];
      end
   end

   // =========================================================
   // State register; reset clears Q so pins show high
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_reg          <= '0;
         st_reg.q        <= REG_RESET;  // [RULE7]
         st_reg.pin      <= 8'hFF;
         st_reg.pin_oe_n <= 8'hFF;
      end else begin
         st_reg <= st_next;
      end
   end

   assign io_out_o       = st_reg.pin;
   assign io_oe_n_o      = st_reg.pin_oe_n;
   assign verify_data_o  = st_reg.vdata;
   assign verify_valid_o = st_reg.vvalid;
   assign secure_o       = st_reg.secure;

endmodule : sop_logic_device

// [rtl/sop_term_array.sv]
// Programmable AND array: forms every product term from the literals
`timescale 1ns/10ps
module sop_term_array
   import sop_logic_pkg::*;
(
   input  wire logic [sop_logic_pkg::NUM_ARRAY_IN-1:0] array_in_i,  // Array inputs
   input  wire logic [sop_logic_pkg::FUSE_BITS-1:0]    fuse_i,      // Programmed cells
   output      logic [sop_logic_pkg::NUM_TERMS-1:0]    term_o       // Product terms
);

   logic [NUM_LIT-1:0] lit;

   // =========================================================
   // Literals: true form in even slots, complement in odd slots
   genvar gi;
   generate
      for (gi = 0; gi < NUM_ARRAY_IN; gi++) begin : g_lit
         assign lit[2*gi]   = array_in_i[gi];
         assign lit[2*gi+1] = ~array_in_i[gi];
      end
   endgenerate

   // =========================================================
   // Each term ANDs the literals still connected; an erased term sees x and ~x, so is low
   genvar gt;
   generate
      for (gt = 0; gt < NUM_TERMS; gt++) begin : g_term
         assign term_o[gt] = &(lit | fuse_i[gt*NUM_LIT +: NUM_LIT]);  // [RULE3]
      end
   endgenerate

endmodule : sop_term_array

// [tb/sop_board_model.sv]
// Board-side model: resolves the shared output pins seen by the device
`timescale 1ns/10ps
module sop_board_model (
   input  wire logic [7:0] io_out_i,   // Device pin levels
   input  wire logic [7:0] io_oe_n_i,  // Device enables, low drives
   output      logic [7:0] io_in_o     // Resolved pin levels
);
   // ==========================================
   // Pin resolution
   // Released pins fall to the board pull-down, never the stale level
   assign io_in_o = ~io_oe_n_i & io_out_i;
endmodule : sop_board_model

// [tb/sop_logic_device_sva.sv]
// Port checker for the registered logic device
`timescale 1ns/10ps
module sop_logic_device_sva
   import sop_logic_pkg::*;
(
   input wire logic                    sys_clk_i,       // Clock
   input wire logic                    rst_i,           // Reset
   input wire logic                    dev_clk_i,       // Device clock pin
   input wire logic                    reg_oe_n_i,      // Register enable
   input wire sop_logic_pkg::arrange_e arrange_i,       // Arrangement
   input wire logic                    secure_set_i,    // Security set
   input wire logic                    preload_i,       // Preload strobe
   input wire logic [7:0]              preload_data_i,  // Preload data
   input wire logic                    verify_i,        // Verify request
   input wire logic [7:0]              io_out_o,        // Pin levels
   input wire logic [7:0]              io_oe_n_o,       // Pin enables
   input wire logic [31:0]             verify_data_o,   // Readback row
   input wire logic                    verify_valid_o,  // Readback strobe
   input wire logic                    secure_o         // Security state
);
   // ==========================================
   // Properties
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   AST_RESET_PINS: assert property ($fell(rst_i) |-> io_out_o == 8'hFF && io_oe_n_o == 8'hFF)
      else $error("pins not high after reset");
   // Quiet clock pin means registered pins may not move
   AST_CAPTURE_EDGE: assert property ((!dev_clk_i && !preload_i && arrange_i == ARR_ALL_REG)[*6] |-> $stable(io_out_o))
      else $error("registered pins moved without clock");
   AST_OE_FOLLOW: assert property ((!reg_oe_n_i && arrange_i == ARR_ALL_REG)[*5] |-> io_oe_n_o == 8'h00)
      else $error("registered pins not enabled");
   AST_PRELOAD_PIN: assert property (preload_i && arrange_i == ARR_ALL_REG |=> io_out_o == ~$past(preload_data_i))
      else $error("preload not on pins");
   AST_VERIFY_ANSWER: assert property (verify_i |-> ##[1:2] verify_valid_o)
      else $error("verify not answered");
   AST_SECURE_ZERO: assert property (secure_o && verify_i |-> ##[1:2] (verify_valid_o && verify_data_o == 32'h0))
      else $error("secured readback leaked data");
   AST_SECURE_STICKY: assert property (secure_o |=> secure_o)
      else $error("security dropped");
   AST_SECURE_SET: assert property (secure_set_i |-> ##[1:2] secure_o)
      else $error("security not set");
endmodule : sop_logic_device_sva

bind sop_logic_device sop_logic_device_sva sop_logic_device_sva_inst (.sys_clk_i, .rst_i, .dev_clk_i, .reg_oe_n_i,
   .arrange_i, .secure_set_i, .preload_i, .preload_data_i, .verify_i, .io_out_o, .io_oe_n_o, .verify_data_o,
   .verify_valid_o, .secure_o);

// [tb/tb_top.sv]
// Testbench: arrangements, feedback, preload and protected readback
`timescale 1ns/10ps
module tb_top;
   import sop_logic_pkg::*;
   logic sys_clk_i, rst_i = 1'b1, dev_clk_i = 1'b0, reg_oe_n_i = 1'b0, secure_set_i = 1'b0;
   logic preload_i = 1'b0, verify_i = 1'b0, probe = 1'b0, verify_valid_o, secure_o;
   logic [7:0] ded_in_i = 8'h00, preload_data_i = 8'h00, io_in_i, io_out_o, io_oe_n_o, q, mask;
   logic [FUSE_BITS-1:0] fuse_i = '0;
   logic [NUM_TERMS-1:0] oe_term_sel_i = '0;
   logic [5:0] verify_term_i = 6'h00;
   logic [31:0] verify_data_o, seed = 32'h53, expq[$];
   arrange_e arrange_i = ARR_ALL_REG;
   int mismatches = 0, comparisons = 0;
   arrange_e modes[4] = '{ARR_ALL_REG, ARR_ALL_COMB, ARR_R6_C2, ARR_R4_C4};
   logic [7:0] masks[4] = '{REG_MASK_ALL, REG_MASK_NONE, REG_MASK_R6, REG_MASK_R4};

   sop_logic_device sop_logic_device_inst (.sys_clk_i, .rst_i, .dev_clk_i, .ded_in_i, .reg_oe_n_i, .io_in_i,
      .arrange_i, .fuse_i, .oe_term_sel_i, .secure_set_i, .preload_i, .preload_data_i, .verify_i,
      .verify_term_i, .io_out_o, .io_oe_n_o, .verify_data_o, .verify_valid_o, .secure_o);
   sop_board_model sop_board_model_inst (.io_out_i(io_out_o), .io_oe_n_i(io_oe_n_o), .io_in_o(io_in_i));

   // ==========================================
   // Clock and helpers
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : cyc
   task automatic probe_pins(input logic [7:0] exp, input logic [7:0] oe);
      expq.push_back({16'h0, oe, exp});
      probe = 1'b1;
      cyc(1);
      probe = 1'b0;
   endtask : probe_pins
   // Expectation ignores secure_o so a stuck flag cannot hide itself
   task automatic read_row(input logic locked);
      logic [5:0] r;
      r = 6'(rnd()) & 6'h39;
      verify_term_i = r;
      verify_i = 1'b1;
      expq.push_back(locked ? 32'h0 : fuse_i[r*32 +: 32]);
      cyc(1);
      verify_i = 1'b0;
      cyc(3);
   endtask : read_row
   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   // ==========================================
   // Result monitor, oldest note first
   always @(posedge sys_clk_i) begin
      if (verify_valid_o || probe) begin
         comparisons++;
         if (expq.size() == 0 || (verify_valid_o ? verify_data_o : {16'h0, io_oe_n_o, io_out_o}) !== expq[0]) begin
            mismatches++;
            $display("CHECK FAILED %0t result differs from expected", $time);
         end
         if (expq.size() != 0) void'(expq.pop_front());
      end
   end

   // ==========================================
   // Stimulus: term m*8 is ded AND feedback, term m*8+1 is NOT ded
   initial begin
      for (int m = 0; m < 8; m++) begin
         fuse_i[m*256 +: 32] = ~((32'h1 << (2*m)) | (32'h1 << (16 + 2*m)));
         fuse_i[m*256+32 +: 32] = ~(32'h1 << (2*m + 1));
      end
      cyc(10);
      rst_i = 1'b0;
      cyc(3);
      probe_pins(8'hFF, 8'h00);
      foreach (modes[i]) begin
         rst_i = 1'b1;
         arrange_i = modes[i];
         mask = masks[i];
         cyc(2);
         rst_i = 1'b0;
         cyc(3);
         preload_data_i = 8'(rnd());
         preload_i = 1'b1;
         cyc(1);
         preload_i = 1'b0;
         q = preload_data_i & mask;
         cyc(4);
         probe_pins(~q & mask | ded_in_i & ~mask, 8'h00);
         // Disabled register pins float; combinational pins keep their own enable
         reg_oe_n_i = 1'b1;
         cyc(4);
         probe_pins(~q & mask | ded_in_i & ~mask, mask);
         reg_oe_n_i = 1'b0;
         cyc(4);
         repeat (4) begin
            ded_in_i = 8'(rnd());
            cyc(4);
            dev_clk_i = 1'b1;
            cyc(3);
            dev_clk_i = 1'b0;
            q = (ded_in_i & ~q | ~ded_in_i) & mask;
            cyc(3);
            probe_pins(~q & mask | ded_in_i & ~mask, 8'h00);
         end
      end
      repeat (3) read_row(1'b0);
      secure_set_i = 1'b1;
      cyc(1);
      secure_set_i = 1'b0;
      cyc(2);
      read_row(1'b1);
      complete_run();
   end

   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #100000;
      mismatches++;
      complete_run();
   end
endmodule : tb_top
